// [hw/gx_dev.sv]
// Device end: serial slave and register pairs of the GPIO expander
// Behaviour
// - Master writes: address with R/W low, command
// - Command byte sets the register pointer
// - Next written byte goes to pair partner
// - Unlimited write bytes, only the pair toggles
// - Master reads: address, command, restart, address+read
// - Read returns addressed register, then alternates
// - Master not-acknowledges the final read byte
// - After restart, reading resumes at pair partner
// - Pins captured at acknowledge clock rise
// - STOP anywhere; last acknowledged data stays valid
// - Direct read uses stored pointer immediately
// - Master starts only on an idle bus
// - Reset release initialises registers and state machine
// - Reset entry puts device in reset
// - Only power-on reset restores defaults
// - Input port registers ignore writes
// - Output registers read back latched value
// - Reading a port clears its change alert
// - Direction pair sits at pointers 06h, 07h
module gx_dev
    import gx_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = GX_SLAVE_ADDR
) (
    input logic core_clk,
    input logic srst,
    gx_link_if.dev link,
    input logic [15:0] pin_in,
    output logic [15:0] out_latch,
    output logic [15:0] dir_input,
    output logic alert_n
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    gx_dev_state_e state;
    gx_dev_state_e next_state;
    logic scl_q;
    logic sda_q;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic [2:0] ptr;
    logic [2:0] next_ptr;
    logic rw;
    logic next_rw;
    logic sda_oe;
    logic next_sda_oe;
    logic [1:0][7:0] in_r;
    logic [1:0][7:0] next_in;
    logic [1:0][7:0] out_r;
    logic [1:0][7:0] next_out;
    logic [1:0][7:0] pol_r;
    logic [1:0][7:0] next_pol;
    logic [1:0][7:0] cfg_r;
    logic [1:0][7:0] next_cfg;
    logic next_alert_n;
    logic [1:0][7:0] pin_v;
    logic rise;
    logic fall;
    logic start_det;
    logic stop_det;

    assign pin_v = pin_in;
    assign rise = link.scl & ~scl_q;
    assign fall = ~link.scl & scl_q;
    assign start_det = link.scl & scl_q & sda_q & ~link.sda;
    assign stop_det = link.scl & scl_q & ~sda_q & link.sda;
    assign out_latch = out_r;
    assign dir_input = cfg_r;
    assign link.dev_sda_oe = sda_oe;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Output pair returns the latch, never the pin level
    function automatic logic [7:0] gx_pick(input logic [2:0] p, input logic [1:0][7:0] iv,
                                           input logic [1:0][7:0] ov, input logic [1:0][7:0] nv,
                                           input logic [1:0][7:0] cv);
        logic [7:0] v;
        v = iv[p[0]];
        if (p[2:1] == GX_PAIR_OUT) begin
            v = ov[p[0]];
        end else if (p[2:1] == GX_PAIR_POL) begin
            v = nv[p[0]];
        end else if (p[2:1] == GX_PAIR_CFG) begin
            v = cv[p[0]];
        end
        return v;
    endfunction : gx_pick

    // Inversion only touches pins set as inputs
    function automatic logic [7:0] gx_pin_view(input logic [7:0] pin, input logic [7:0] pol,
                                               input logic [7:0] cfg);
        return pin ^ (pol & cfg);
    endfunction : gx_pin_view

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [7:0] rd;
        logic [2:0] np;
        rd = gx_pick(ptr, in_r, out_r, pol_r, cfg_r);
        np = {ptr[2:1], ~ptr[0]};
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_ptr = ptr;
        next_rw = rw;
        next_sda_oe = sda_oe;
        next_in = in_r;
        next_out = out_r;
        next_pol = pol_r;
        next_cfg = cfg_r;
        if (stop_det) begin
            // A partial byte is dropped; committed bytes and pointer stay
            next_state = GX_D_IDLE;
            next_sda_oe = 1'h0;
        end else if (start_det) begin
            next_state = GX_D_ADDR;
            next_cnt = 3'h0;
            next_sda_oe = 1'h0;
        end else begin
            case (state)
                GX_D_ADDR, GX_D_CMD, GX_D_WDAT: begin
                    if (rise) begin
                        next_sh = {sh[6:0], link.sda};
                        next_cnt = cnt + 3'h1;
                        if (cnt == 3'h7) begin
                            if (state == GX_D_ADDR) begin
                                if (sh[6:0] == SLAVE_ADDR) begin
                                    next_state = GX_D_AACK;
                                    next_rw = link.sda;
                                end else begin
                                    next_state = GX_D_WAIT;
                                end
                            end else if (state == GX_D_CMD) begin
                                next_state = GX_D_CACK;
                            end else begin
                                next_state = GX_D_WACK;
                            end
                        end
                    end
                end
                GX_D_AACK, GX_D_CACK, GX_D_WACK: begin
                    if (fall) begin
                        if (!sda_oe) begin
                            next_sda_oe = 1'h1;
                        end else if (state == GX_D_AACK && rw) begin
                            // Direct read starts at the stored pointer
                            next_state = GX_D_RDAT;
                            next_cnt = 3'h0;
                            next_sda_oe = ~rd[7];
                            next_sh = {rd[6:0], 1'h0};
                        end else begin
                            next_sda_oe = 1'h0;
                            next_cnt = 3'h0;
                            next_state = (state == GX_D_AACK) ? GX_D_CMD : GX_D_WDAT;
                        end
                    end else if (rise) begin
                        if (state == GX_D_AACK && rw && ptr[2:1] == GX_PAIR_IN) begin
                            // Capture also resyncs the change alert of this port
                            next_in[ptr[0]] = gx_pin_view(pin_v[ptr[0]], pol_r[ptr[0]], cfg_r[ptr[0]]);
                        end else if (state == GX_D_CACK) begin
                            next_ptr = sh[2:0];
                        end else if (state == GX_D_WACK) begin
                            // Byte commits only at its acknowledge
                            if (ptr[2:1] == GX_PAIR_OUT) begin
                                next_out[ptr[0]] = sh;
                            end else if (ptr[2:1] == GX_PAIR_POL) begin
                                next_pol[ptr[0]] = sh;
                            end else if (ptr[2:1] == GX_PAIR_CFG) begin
                                next_cfg[ptr[0]] = sh;
                            end
                            // Input pair falls through unchanged
                            next_ptr = np;
                        end
                    end
                end
                GX_D_RDAT: begin
                    if (rise) begin
                        next_cnt = cnt + 3'h1;
                        if (cnt == 3'h7) begin
                            next_state = GX_D_RACK;
                        end
                    end else if (fall) begin
                        next_sda_oe = ~sh[7];
                        next_sh = {sh[6:0], 1'h0};
                    end
                end
                GX_D_RACK: begin
                    if (fall) begin
                        next_sda_oe = 1'h0;
                    end else if (rise) begin
                        // Toggle even on the final byte so a restart resumes at the partner
                        next_ptr = np;
                        if (link.sda) begin
                            next_state = GX_D_WAIT;
                        end else begin
                            next_state = GX_D_RNXT;
                            if (np[2:1] == GX_PAIR_IN) begin
                                next_in[np[0]] = gx_pin_view(pin_v[np[0]], pol_r[np[0]], cfg_r[np[0]]);
                            end
                        end
                    end
                end
                GX_D_RNXT: begin
                    if (fall) begin
                        next_state = GX_D_RDAT;
                        next_cnt = 3'h0;
                        next_sda_oe = ~rd[7];
                        next_sh = {rd[6:0], 1'h0};
                    end
                end
                default: begin
                end
            endcase
        end
        next_alert_n = 1'h1;
        for (int k = 0; k < 2; k++) begin
            if (|((gx_pin_view(pin_v[k], pol_r[k], cfg_r[k]) ^ in_r[k]) & cfg_r[k])) begin
                next_alert_n = 1'h0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    // srst is the power-on reset; there is no other way back to defaults
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= GX_D_IDLE;
            scl_q <= 1'h1;
            sda_q <= 1'h1;
            cnt <= 3'h0;
            sh <= 8'h00;
            ptr <= GX_RST_PTR;
            rw <= 1'h0;
            sda_oe <= 1'h0;
            in_r <= pin_in;
            out_r <= {GX_RST_OUT, GX_RST_OUT};
            pol_r <= {GX_RST_POL, GX_RST_POL};
            cfg_r <= {GX_RST_CFG, GX_RST_CFG};
            alert_n <= 1'h1;
            link.dev_sda_o <= 1'h0;
        end else begin
            state <= next_state;
            scl_q <= link.scl;
            sda_q <= link.sda;
            cnt <= next_cnt;
            sh <= next_sh;
            ptr <= next_ptr;
            rw <= next_rw;
            sda_oe <= next_sda_oe;
            in_r <= next_in;
            out_r <= next_out;
            pol_r <= next_pol;
            cfg_r <= next_cfg;
            alert_n <= next_alert_n;
            link.dev_sda_o <= 1'h0;
        end
    end
endmodule : gx_dev

// [common/gx_pkg.sv]
// Shared constants and types for the GPIO expander serial link pair
package gx_pkg;
    // ---------------------------------------------------------------
    // Register pointer map
    // ---------------------------------------------------------------
    localparam logic [1:0] GX_PAIR_IN = 2'h0;
    localparam logic [1:0] GX_PAIR_OUT = 2'h1;
    localparam logic [1:0] GX_PAIR_POL = 2'h2;
    localparam logic [1:0] GX_PAIR_CFG = 2'h3;
    localparam logic [2:0] GX_REG_IN0 = 3'h0;
    localparam logic [2:0] GX_REG_OUT0 = 3'h2;
    localparam logic [2:0] GX_REG_OUT1 = 3'h3;
    localparam logic [2:0] GX_REG_CFG0 = 3'h6;
    localparam logic [2:0] GX_REG_CFG1 = 3'h7;
    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] GX_RST_OUT = 8'hFF;
    localparam logic [7:0] GX_RST_POL = 8'h00;
    localparam logic [7:0] GX_RST_CFG = 8'hFF;
    localparam logic [2:0] GX_RST_PTR = GX_REG_IN0;
    // Default 7-bit slave address, arbitrary value
    localparam logic [6:0] GX_SLAVE_ADDR = 7'h20;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int GX_CLK_PERIOD_NS = 25;
    localparam int GX_SCL_PERIOD_NS = 2500;
    localparam int GX_QTR_CYC = (GX_SCL_PERIOD_NS / 4 + GX_CLK_PERIOD_NS - 1) / GX_CLK_PERIOD_NS;
    // ---------------------------------------------------------------
    // State types
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        GX_D_IDLE = 4'h0,
        GX_D_ADDR = 4'h1,
        GX_D_AACK = 4'h3,
        GX_D_CMD = 4'h2,
        GX_D_CACK = 4'h6,
        GX_D_WDAT = 4'h7,
        GX_D_WACK = 4'h5,
        GX_D_RDAT = 4'h4,
        GX_D_RACK = 4'hC,
        GX_D_RNXT = 4'hD,
        GX_D_WAIT = 4'h8
    } gx_dev_state_e;
    typedef enum logic [2:0] {
        GX_H_IDLE = 3'h0,
        GX_H_START = 3'h1,
        GX_H_BIT = 3'h3,
        GX_H_RSTART = 3'h2,
        GX_H_STOP = 3'h6
    } gx_host_state_e;
    typedef enum logic [1:0] {
        GX_ST_ADDRW = 2'h0,
        GX_ST_CMD = 2'h1,
        GX_ST_ADDRR = 2'h3,
        GX_ST_DATA = 2'h2
    } gx_stage_e;
endpackage : gx_pkg

// [common/gx_link_if.sv]
// Two-wire link between the expander and its bus master, open-drain resolved
interface gx_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    // Pull-ups hold a line high unless a driver pulls it low
    assign scl = host_scl_oe ? host_scl_o : 1'h1;
    assign sda = (host_sda_oe ? host_sda_o : 1'h1) & (dev_sda_oe ? dev_sda_o : 1'h1);
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o,
                  output host_sda_oe);
endinterface : gx_link_if

// [hw/gx_host.sv]
// Host end: bus master that writes and reads the expander register pairs
module gx_host
    import gx_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = GX_SLAVE_ADDR,
    parameter int QTR_CYC = GX_QTR_CYC
) (
    input logic core_clk,
    input logic srst,
    gx_link_if.host link,
    input logic req,
    input logic op_read,
    input logic use_cmd,
    input logic [7:0] cmd_byte,
    input logic [7:0] nbytes,
    input logic [7:0] wr_byte,
    output logic wr_take,
    output logic [7:0] rd_byte,
    output logic rd_valid,
    output logic busy,
    output logic nack_err
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    gx_host_state_e state;
    gx_host_state_e next_state;
    gx_stage_e stage;
    gx_stage_e next_stage;
    logic [7:0] div;
    logic [7:0] next_div;
    logic [1:0] ph;
    logic [1:0] next_ph;
    logic [3:0] bitn;
    logic [3:0] next_bitn;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic [7:0] left;
    logic [7:0] next_left;
    logic rd_op;
    logic next_rd_op;
    logic acked;
    logic next_acked;
    logic scl_oe;
    logic next_scl_oe;
    logic sda_oe;
    logic next_sda_oe;
    logic next_wr_take;
    logic [7:0] next_rd_byte;
    logic next_rd_valid;
    logic next_busy;
    logic next_nack_err;
    logic tick;
    logic rx;

    assign tick = (div == 8'(QTR_CYC - 1));
    assign rx = (stage == GX_ST_DATA) && rd_op;
    assign link.host_scl_oe = scl_oe;
    assign link.host_sda_oe = sda_oe;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_stage = stage;
        next_div = (state == GX_H_IDLE || tick) ? 8'h00 : div + 8'h01;
        next_ph = ph;
        next_bitn = bitn;
        next_sh = sh;
        next_left = left;
        next_rd_op = rd_op;
        next_acked = acked;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_wr_take = 1'h0;
        next_rd_byte = rd_byte;
        next_rd_valid = 1'h0;
        next_busy = busy;
        next_nack_err = nack_err;
        if (state == GX_H_IDLE) begin
            // Idle means both lines released and no frame open
            if (req) begin
                next_state = GX_H_START;
                next_busy = 1'h1;
                next_nack_err = 1'h0;
                next_rd_op = op_read;
                next_left = (op_read && nbytes == 8'h00) ? 8'h01 : nbytes;
                next_ph = 2'h0;
                next_bitn = 4'h0;
                if (use_cmd || !op_read) begin
                    next_stage = GX_ST_ADDRW;
                    next_sh = {TARGET_ADDR, 1'h0};
                end else begin
                    next_stage = GX_ST_ADDRR;
                    next_sh = {TARGET_ADDR, 1'h1};
                end
            end
        end else if (tick) begin
            next_ph = ph + 2'h1;
            case (state)
                GX_H_START, GX_H_RSTART: begin
                    if (ph == 2'h0) begin
                        next_sda_oe = (state == GX_H_START);
                    end else if (ph == 2'h1) begin
                        next_scl_oe = 1'h0;
                    end else if (ph == 2'h2) begin
                        next_sda_oe = 1'h1;
                    end else begin
                        next_scl_oe = 1'h1;
                        next_state = GX_H_BIT;
                    end
                end
                GX_H_STOP: begin
                    if (ph == 2'h0) begin
                        next_sda_oe = 1'h1;
                    end else if (ph == 2'h1) begin
                        next_scl_oe = 1'h0;
                    end else if (ph == 2'h2) begin
                        next_sda_oe = 1'h0;
                    end else begin
                        next_state = GX_H_IDLE;
                        next_busy = 1'h0;
                    end
                end
                GX_H_BIT: begin
                    if (ph == 2'h0) begin
                        // Acknowledge all read bytes but the last
                        next_sda_oe = (bitn == 4'h8) ? (rx && left != 8'h01) : (!rx && !sh[7]);
                    end else if (ph == 2'h1) begin
                        next_scl_oe = 1'h0;
                    end else if (ph == 2'h2) begin
                        if (bitn == 4'h8) begin
                            next_acked = ~link.sda;
                        end else begin
                            next_sh = {sh[6:0], link.sda};
                        end
                    end else begin
                        next_scl_oe = 1'h1;
                        next_bitn = bitn + 4'h1;
                        if (bitn == 4'h8) begin
                            next_bitn = 4'h0;
                            if (!rx && !acked) begin
                                next_nack_err = 1'h1;
                                next_state = GX_H_STOP;
                            end else if (stage == GX_ST_ADDRW) begin
                                next_stage = GX_ST_CMD;
                                next_sh = cmd_byte;
                            end else if (stage == GX_ST_CMD && rd_op) begin
                                next_state = GX_H_RSTART;
                                next_stage = GX_ST_ADDRR;
                                next_sh = {TARGET_ADDR, 1'h1};
                            end else if (stage != GX_ST_DATA && left == 8'h00) begin
                                next_state = GX_H_STOP;
                            end else if (stage != GX_ST_DATA) begin
                                next_stage = GX_ST_DATA;
                                next_sh = wr_byte;
                                next_wr_take = !rd_op;
                            end else begin
                                next_left = left - 8'h01;
                                next_rd_byte = sh;
                                next_rd_valid = rd_op;
                                if (left == 8'h01) begin
                                    next_state = GX_H_STOP;
                                end else begin
                                    next_sh = wr_byte;
                                    next_wr_take = !rd_op;
                                end
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= GX_H_IDLE;
            stage <= GX_ST_ADDRW;
            div <= 8'h00;
            ph <= 2'h0;
            bitn <= 4'h0;
            sh <= 8'h00;
            left <= 8'h00;
            rd_op <= 1'h0;
            acked <= 1'h0;
            scl_oe <= 1'h0;
            sda_oe <= 1'h0;
            wr_take <= 1'h0;
            rd_byte <= 8'h00;
            rd_valid <= 1'h0;
            busy <= 1'h0;
            nack_err <= 1'h0;
            link.host_scl_o <= 1'h0;
            link.host_sda_o <= 1'h0;
        end else begin
            state <= next_state;
            stage <= next_stage;
            div <= next_div;
            ph <= next_ph;
            bitn <= next_bitn;
            sh <= next_sh;
            left <= next_left;
            rd_op <= next_rd_op;
            acked <= next_acked;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            wr_take <= next_wr_take;
            rd_byte <= next_rd_byte;
            rd_valid <= next_rd_valid;
            busy <= next_busy;
            nack_err <= next_nack_err;
            link.host_scl_o <= 1'h0;
            link.host_sda_o <= 1'h0;
        end
    end
endmodule : gx_host

// [sim/gx_props.sv]
// Link checker for the expander pair
module gx_props (
    input logic core_clk,
    input logic srst,
    input logic host_scl_oe,
    input logic host_sda_oe,
    input logic dev_sda_oe,
    input logic scl,
    input logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    property p_rst; $fell(srst) |-> !dev_sda_oe && !host_scl_oe && !host_sda_oe; endproperty
    property p_dev_on; $rose(dev_sda_oe) |-> !scl; endproperty
    property p_dev_off; $fell(dev_sda_oe) |-> !scl; endproperty
    property p_dev_lag; $fell(scl) |-> $stable(dev_sda_oe); endproperty
    property p_scl_hi; $rose(scl) |-> scl [*4]; endproperty
    property p_start; $fell(sda) && scl |-> host_sda_oe; endproperty
    property p_stop; $rose(sda) && scl |-> $fell(host_sda_oe); endproperty
    property p_scl_lo; !scl |-> ##[0:200] scl; endproperty
    a_rst: assert property (p_rst) else $error("lines driven after reset");
    a_dev_on: assert property (p_dev_on) else $error("device drive while scl high");
    a_dev_off: assert property (p_dev_off) else $error("device release while scl high");
    a_dev_lag: assert property (p_dev_lag) else $error("device answered too early");
    a_scl_hi: assert property (p_scl_hi) else $error("scl high too short");
    a_start: assert property (p_start) else $error("start not made by host");
    a_stop: assert property (p_stop) else $error("stop not made by host");
    a_scl_lo: assert property (p_scl_lo) else $error("scl stuck low");
    c_ack: cover property ($rose(dev_sda_oe));
    c_start: cover property ($fell(sda) && scl);
    c_stop: cover property ($rose(sda) && scl);
endmodule : gx_props

// [sim/tb.sv]
// Self-checking bench joining host and expander ends
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'h0;
    logic srst = 1'h1;
    logic req = 1'h0, op_read = 1'h0, use_cmd = 1'h0;
    logic [7:0] cmd_byte = 8'h00, nbytes = 8'h00, wr_byte = 8'h00, rd_byte;
    logic [15:0] pin_in = 16'h1234, out_latch, dir_input;
    logic wr_take, rd_valid, busy, nack_err, alert_n;
    int bad_count = 0, n_compared = 0, cyc = 0;
    gx_link_if link();
    gx_dev gx_dev_inst (.core_clk(core_clk), .srst(srst), .link(link.dev), .pin_in(pin_in),
        .out_latch(out_latch), .dir_input(dir_input), .alert_n(alert_n));
    // Short quarter keeps the run brief, still above the edge-detect minimum
    gx_host #(.QTR_CYC(3)) gx_host_inst (.core_clk(core_clk), .srst(srst), .link(link.host), .req(req),
        .op_read(op_read), .use_cmd(use_cmd), .cmd_byte(cmd_byte), .nbytes(nbytes), .wr_byte(wr_byte),
        .wr_take(wr_take), .rd_byte(rd_byte), .rd_valid(rd_valid), .busy(busy), .nack_err(nack_err));
    gx_props gx_props_inst (.core_clk(core_clk), .srst(srst), .host_scl_oe(link.host_scl_oe),
        .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        n_compared++;
        if (a !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask : chk
    // Each wr_take means the current wr_byte was loaded; the next entry follows
    task automatic xfer(input logic rd, input logic uc, input logic [2:0] ptr, input logic [7:0] n,
            input logic [7:0] d[6]);
        int kw = 0;
        int kr = 0;
        int t = 0;
        {op_read, use_cmd, cmd_byte, nbytes, wr_byte, req} = {rd, uc, 5'h00, ptr, n, d[0], 1'h1};
        @(posedge core_clk);
        #2 req = 1'h0;
        while (busy === 1'h1 && t < 9000) begin
            @(posedge core_clk);
            #2 t++;
            if (wr_take === 1'h1) wr_byte = d[++kw];
            if (rd_valid === 1'h1) chk({8'h00, rd_byte}, {8'h00, d[kr++]});
        end
        chk({15'h0000, busy}, 16'h0000);
        if (rd) chk(kr[15:0], {8'h00, n});
        chk({15'h0000, nack_err}, 16'h0000);
    endtask : xfer
    task automatic t_reset();
        chk(out_latch, 16'hFFFF);
        chk(dir_input, 16'hFFFF);
        chk({15'h0000, alert_n}, 16'h0001);
        $display("reset test done");
    endtask : t_reset
    task automatic t_write();
        xfer(1'h0, 1'h1, 3'h0, 8'h01, '{8'h77, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk(out_latch, 16'hFFFF);
        xfer(1'h0, 1'h1, 3'h3, 8'h03, '{8'hA5, 8'h3C, 8'h5A, 8'h00, 8'h00, 8'h00});
        chk(out_latch, 16'h5A3C);
        chk(dir_input, 16'hFFFF);
        $display("write test done");
    endtask : t_write
    task automatic t_read();
        xfer(1'h1, 1'h1, 3'h3, 8'h03, '{8'h5A, 8'h3C, 8'h5A, 8'h00, 8'h00, 8'h00});
        xfer(1'h1, 1'h0, 3'h0, 8'h01, '{8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        $display("read test done");
    endtask : t_read
    task automatic t_input();
        xfer(1'h1, 1'h1, 3'h1, 8'h02, '{8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h00});
        pin_in = 16'h1235;
        repeat (10) @(posedge core_clk);
        #2 chk({15'h0000, alert_n}, 16'h0000);
        xfer(1'h1, 1'h1, 3'h0, 8'h01, '{8'h35, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk({15'h0000, alert_n}, 16'h0001);
        // Inversion shows in the input pair and holds the alert until both ports are read
        xfer(1'h0, 1'h1, 3'h4, 8'h02, '{8'h01, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00});
        chk({15'h0000, alert_n}, 16'h0000);
        xfer(1'h1, 1'h1, 3'h5, 8'h02, '{8'h80, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00});
        xfer(1'h1, 1'h1, 3'h0, 8'h02, '{8'h34, 8'h92, 8'h00, 8'h00, 8'h00, 8'h00});
        chk({15'h0000, alert_n}, 16'h0001);
        $display("input test done");
    endtask : t_input
    task automatic t_cfg();
        xfer(1'h0, 1'h1, 3'h6, 8'h02, '{8'h0F, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00});
        chk(dir_input, 16'hF00F);
        xfer(1'h1, 1'h1, 3'h7, 8'h02, '{8'hF0, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00});
        $display("config test done");
    endtask : t_cfg
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(posedge core_clk);
        #2 srst = 1'h0;
        t_reset();
        t_write();
        t_read();
        t_input();
        t_cfg();
        final_report();
    end
endmodule : tb
